// ---- design/ilb_host.sv ----
// Operation
// - Link uses one to twenty-four lanes
// - Lane word width 32, 40 or 64
// - No double rate fabric transfer
// - TX and RX FIFOs run elastic, flags exported
// - Writes paced by TX FIFO flags
// - Frame generator reads only while burst enabled
// - Pre-fill all lanes full after TX reset
// - Write 250 ns after all locks, single immediately
// - After pre-fill, burst on, MAC writes by flags
// - Underflow, lost lock or disable forces reset and pre-fill
// - Single lane skips soft bonding pre-fill
// - RX reads held off until deskew done
// - RX FIFO fills from first sync word
// - All pempty clear first: read all lanes together
// - Any pfull first: align-clear four cycles, retry
//
// The register offsets and the APB register port were left to the implementer.
`include "ilb_defines.svh"

module ilb_host (
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [11:0]             PADDR,
	input  wire logic [31:0]             PWDATA,
	output logic [31:0]                  PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	output logic                         IRQ,
	input  wire ilb_pkg::ilb_lane_data_t MAC_TX_DATA,
	input  wire logic                    MAC_TX_VALID,
	output logic                         MAC_TX_READY,
	output ilb_pkg::ilb_lane_data_t      MAC_RX_DATA,
	output logic                         MAC_RX_VALID,
	ilb_if.mac                           LNK
);
	import ilb_pkg::*;

	ilb_host_t             s_reg;
	ilb_host_t             s_next;
	ilb_lanes_t            mask;
	logic                  all_lock;
	logic                  all_full;
	logic                  multi;
	logic                  tx_err;
	logic                  wr_acc;
	logic [`ILB_EV_W-1:0]  ev;
	logic [`ILB_EV_W-1:0]  clr;

	always_comb begin
		s_next = s_reg;
		ev = '0;
		clr = '0;
		mask = ilb_lane_mask(s_reg.lane_cnt);
		multi = (mask != ilb_lanes_t'(1));
		all_lock = &(LNK.tx_lock | ~mask);
		all_full = &(LNK.tx_full | ~mask);
		// Underflow only matters once lanes are bonded
		tx_err = s_reg.burst && multi && |(LNK.tx_empty & mask);

		// APB slave: one wait-free access phase
		wr_acc = PSEL && PENABLE && s_reg.pready && PWRITE;
		s_next.pready = PSEL && !PENABLE;
		s_next.pslverr = 1'b0;
		s_next.prdata = '0;
		if (PSEL && !PENABLE) begin
			if (PADDR == `ILB_REG_CTRL) begin
				s_next.prdata = {24'h00_0000, s_reg.width,
					s_reg.lane_cnt, s_reg.en};
			end else if (PADDR == `ILB_REG_STATUS) begin
				s_next.prdata = {22'h00_0000, s_reg.tx_ready,
					s_reg.align_clr, s_reg.rx_st, s_reg.tx_st};
			end else if (PADDR == `ILB_REG_INT_STAT) begin
				s_next.prdata = {28'h000_0000, s_reg.int_stat};
			end else if (PADDR == `ILB_REG_INT_EN) begin
				s_next.prdata = {28'h000_0000, s_reg.int_en};
			end else if (PADDR == `ILB_REG_INT_CLR) begin
				s_next.prdata = '0;
			end else begin
				s_next.pslverr = 1'b1;
			end
		end
		if (wr_acc) begin
			if (PADDR == `ILB_REG_CTRL) begin
				s_next.en = PWDATA[`ILB_CTRL_EN];
				s_next.lane_cnt =
					PWDATA[`ILB_CTRL_LANES_HI:`ILB_CTRL_LANES_LO];
				s_next.width =
					PWDATA[`ILB_CTRL_WIDTH_HI:`ILB_CTRL_WIDTH_LO];
			end else if (PADDR == `ILB_REG_INT_EN) begin
				s_next.int_en = PWDATA[`ILB_EV_W-1:0];
			end else if (PADDR == `ILB_REG_INT_CLR) begin
				clr = PWDATA[`ILB_EV_W-1:0];
			end
		end

		// TX soft bonding
		s_next.wr_en = '0;
		s_next.dig_rst = 1'b0;
		s_next.wdata = MAC_TX_DATA;
		case (s_reg.tx_st)
			ILB_T_RST: begin
				s_next.dig_rst = 1'b1;
				s_next.tcnt = s_reg.tcnt + 8'h01;
				if (s_reg.tcnt >= `ILB_TXRST_CYC) begin
					s_next.tx_st = ILB_T_LOCK;
					s_next.tcnt = '0;
					s_next.dig_rst = 1'b0;
				end
			end
			ILB_T_LOCK: begin
				s_next.tcnt = '0;
				if (s_reg.en && all_lock) begin
					if (multi) begin
						s_next.tx_st = ILB_T_WAIT;
					end else begin
						s_next.tx_st = ILB_T_RUN;
						ev[`ILB_EV_TX_READY] = 1'b1;
					end
				end
			end
			ILB_T_WAIT: begin
				s_next.tcnt = s_reg.tcnt + 8'h01;
				if (s_reg.tcnt >= `ILB_LOCK_WAIT_CYC - 8'h01) begin
					s_next.tx_st = ILB_T_FILL;
				end
			end
			ILB_T_FILL: begin
				// Fill words until every lane reports full
				s_next.wdata = {`ILB_LANES{`ILB_FILL_WORD}};
				s_next.wr_en = mask & ~LNK.tx_full;
				if (all_full && s_reg.wr_en == '0) begin
					s_next.wr_en = '0;
					s_next.tx_st = ILB_T_RUN;
					ev[`ILB_EV_TX_READY] = 1'b1;
				end
			end
			ILB_T_RUN: begin
				if (MAC_TX_VALID && s_reg.tx_ready) begin
					s_next.wr_en = mask;
				end
			end
			default: begin
				s_next.tx_st = ILB_T_RST;
			end
		endcase
		if (s_reg.tx_st != ILB_T_RST && s_reg.tx_st != ILB_T_LOCK
			&& (!s_reg.en || !all_lock || tx_err)) begin
			// Any slip loses bonding: reset and pre-fill again
			s_next.tx_st = ILB_T_RST;
			s_next.tcnt = '0;
			s_next.wr_en = '0;
			ev[`ILB_EV_TX_ERR] = tx_err;
		end
		s_next.burst = (s_next.tx_st == ILB_T_RUN);
		// Partially full leaves room for the two-cycle write latency
		s_next.tx_ready = s_next.burst
			&& !(|(LNK.tx_pfull & mask));

		// RX deskew
		case (s_reg.rx_st)
			ILB_R_WAIT: begin
				s_next.rcnt = '0;
				if (s_reg.en) begin
					if (|(LNK.rx_pfull & mask)) begin
						s_next.rx_st = ILB_R_FLUSH;
						ev[`ILB_EV_RX_FLUSH] = 1'b1;
					end else if (!(|(LNK.rx_pempty & mask))) begin
						s_next.rx_st = ILB_R_ALIGN;
						ev[`ILB_EV_RX_ALIGNED] = 1'b1;
					end
				end
			end
			ILB_R_FLUSH: begin
				s_next.rcnt = s_reg.rcnt + 8'h01;
				if (s_reg.rcnt >= `ILB_FLUSH_CYC - 8'h01) begin
					s_next.rx_st = ILB_R_WAIT;
				end
			end
			ILB_R_ALIGN: begin
				if (!s_reg.en || !(&(LNK.rx_frame_lock | ~mask))) begin
					s_next.rx_st = ILB_R_FLUSH;
					s_next.rcnt = '0;
					ev[`ILB_EV_RX_FLUSH] = 1'b1;
				end
			end
			default: begin
				s_next.rx_st = ILB_R_WAIT;
			end
		endcase
		s_next.align_clr = (s_next.rx_st == ILB_R_FLUSH);
		s_next.rd_en = (s_next.rx_st == ILB_R_ALIGN)
			? mask : '0;
		s_next.rx_data = LNK.rx_data;
		s_next.rx_valid = |(LNK.rx_dval & mask);

		// Set wins over a clear in the same cycle
		s_next.int_stat = (s_reg.int_stat & ~clr) | ev;
		s_next.irq = |(s_next.int_stat & s_next.int_en);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '0;
			s_reg.tx_st <= ILB_T_RST;
			s_reg.rx_st <= ILB_R_WAIT;
			s_reg.lane_cnt <= `ILB_LANES_RST;
			s_reg.width <= `ILB_W64;
		end else begin
			s_reg <= s_next;
		end
	end

	assign PRDATA = s_reg.prdata;
	assign PREADY = s_reg.pready;
	assign PSLVERR = s_reg.pslverr;
	assign IRQ = s_reg.irq;
	assign MAC_TX_READY = s_reg.tx_ready;
	assign MAC_RX_DATA = s_reg.rx_data;
	assign MAC_RX_VALID = s_reg.rx_valid;
	assign LNK.tx_wr_en = s_reg.wr_en;
	assign LNK.tx_data = s_reg.wdata;
	assign LNK.tx_burst_en = s_reg.burst;
	assign LNK.tx_digital_reset = s_reg.dig_rst;
	assign LNK.width_sel = s_reg.width;
	assign LNK.rx_rd_en = s_reg.rd_en;
	assign LNK.rx_align_clr = s_reg.align_clr;

endmodule

// ---- design/ilb_defines.svh ----
`ifndef ILB_DEFINES_SVH
`define ILB_DEFINES_SVH

`define ILB_LANES          24
`define ILB_DW             64
`define ILB_FDEPTH         16
`define ILB_FAW            4
`define ILB_FCW            5
`define ILB_FIFO_FULL_CNT  5'h10
`define ILB_FIFO_PFULL_CNT 5'h0C
`define ILB_FIFO_PEMPTY_CNT 5'h04

`define ILB_CLK_NS         10
`define ILB_LOCK_WAIT_NS   250
`define ILB_LOCK_WAIT_CYC  8'((`ILB_LOCK_WAIT_NS + `ILB_CLK_NS - 1) / `ILB_CLK_NS)
`define ILB_FLUSH_CYC      8'h04
`define ILB_TXRST_CYC      8'h08

`define ILB_W32            2'h0
`define ILB_W40            2'h1
`define ILB_W64            2'h2
`define ILB_MASK32         64'h0000_0000_FFFF_FFFF
`define ILB_MASK40         64'h0000_00FF_FFFF_FFFF
`define ILB_MASK64         64'hFFFF_FFFF_FFFF_FFFF
`define ILB_FILL_WORD      64'h0000_0000_0000_0000

`define ILB_REG_CTRL       12'h000
`define ILB_REG_STATUS     12'h004
`define ILB_REG_INT_STAT   12'h008
`define ILB_REG_INT_EN     12'h00C
`define ILB_REG_INT_CLR    12'h010

`define ILB_CTRL_EN        0
`define ILB_CTRL_LANES_LO  1
`define ILB_CTRL_LANES_HI  5
`define ILB_CTRL_WIDTH_LO  6
`define ILB_CTRL_WIDTH_HI  7
`define ILB_LANES_RST      5'h01

`define ILB_EV_TX_READY    0
`define ILB_EV_TX_ERR      1
`define ILB_EV_RX_ALIGNED  2
`define ILB_EV_RX_FLUSH    3
`define ILB_EV_W           4

`endif

// ---- design/ilb_pkg.sv ----
`include "ilb_defines.svh"

package ilb_pkg;

	typedef logic [`ILB_LANES-1:0]                 ilb_lanes_t;
	typedef logic [`ILB_LANES-1:0][`ILB_DW-1:0]    ilb_lane_data_t;

	typedef enum logic [4:0] {
		ILB_T_RST  = 5'b00001,
		ILB_T_LOCK = 5'b00010,
		ILB_T_WAIT = 5'b00100,
		ILB_T_FILL = 5'b01000,
		ILB_T_RUN  = 5'b10000
	} ilb_tx_state_t;

	typedef enum logic [2:0] {
		ILB_R_WAIT  = 3'b001,
		ILB_R_FLUSH = 3'b010,
		ILB_R_ALIGN = 3'b100
	} ilb_rx_state_t;

	typedef struct packed {
		logic [`ILB_FDEPTH-1:0][`ILB_DW-1:0] mem;
		logic [`ILB_FAW-1:0]                 wp;
		logic [`ILB_FAW-1:0]                 rp;
		logic [`ILB_FCW-1:0]                 cnt;
		logic [`ILB_DW-1:0]                  dout;
		logic                                dval;
		logic                                full;
		logic                                pfull;
		logic                                empty;
		logic                                pempty;
	} ilb_fifo_t;

	typedef struct packed {
		ilb_lanes_t  tx_lock;
		ilb_lanes_t  rx_lock;
		ilb_lanes_t  sync_seen;
	} ilb_dev_t;

	typedef struct packed {
		ilb_tx_state_t       tx_st;
		ilb_rx_state_t       rx_st;
		logic [7:0]          tcnt;
		logic [7:0]          rcnt;
		ilb_lanes_t          wr_en;
		ilb_lane_data_t      wdata;
		logic                burst;
		logic                dig_rst;
		ilb_lanes_t          rd_en;
		logic                align_clr;
		logic                en;
		logic [4:0]          lane_cnt;
		logic [1:0]          width;
		logic [`ILB_EV_W-1:0] int_stat;
		logic [`ILB_EV_W-1:0] int_en;
		logic                pready;
		logic [31:0]         prdata;
		logic                pslverr;
		logic                irq;
		logic                tx_ready;
		ilb_lane_data_t      rx_data;
		logic                rx_valid;
	} ilb_host_t;

	function automatic ilb_lanes_t ilb_lane_mask(input logic [4:0] cnt);
		ilb_lanes_t m;
		m = '0;
		for (int i = 0; i < `ILB_LANES; i++) begin
			if (i < int'(cnt) || i == 0) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic logic [`ILB_DW-1:0] ilb_width_mask(input logic [1:0] w);
		logic [`ILB_DW-1:0] m;
		case (w)
			`ILB_W32: m = `ILB_MASK32;
			`ILB_W40: m = `ILB_MASK40;
			default:  m = `ILB_MASK64;
		endcase
		return m;
	endfunction

endpackage

// ---- design/ilb_if.sv ----
interface ilb_if;
	import ilb_pkg::*;

	ilb_lanes_t     tx_wr_en;
	ilb_lane_data_t tx_data;
	ilb_lanes_t     tx_full;
	ilb_lanes_t     tx_pfull;
	ilb_lanes_t     tx_empty;
	ilb_lanes_t     tx_pempty;
	ilb_lanes_t     tx_lock;
	logic           tx_burst_en;
	logic           tx_digital_reset;
	logic [1:0]     width_sel;
	ilb_lanes_t     rx_rd_en;
	ilb_lane_data_t rx_data;
	ilb_lanes_t     rx_dval;
	ilb_lanes_t     rx_pfull;
	ilb_lanes_t     rx_pempty;
	ilb_lanes_t     rx_empty;
	ilb_lanes_t     rx_frame_lock;
	logic           rx_align_clr;

	modport dev (
		input  tx_wr_en, tx_data, tx_burst_en, tx_digital_reset, width_sel,
		input  rx_rd_en, rx_align_clr,
		output tx_full, tx_pfull, tx_empty, tx_pempty, tx_lock,
		output rx_data, rx_dval, rx_pfull, rx_pempty, rx_empty, rx_frame_lock
	);

	modport mac (
		output tx_wr_en, tx_data, tx_burst_en, tx_digital_reset, width_sel,
		output rx_rd_en, rx_align_clr,
		input  tx_full, tx_pfull, tx_empty, tx_pempty, tx_lock,
		input  rx_data, rx_dval, rx_pfull, rx_pempty, rx_empty, rx_frame_lock
	);

endinterface

// ---- design/ilb_lane_fifo.sv ----
`include "ilb_defines.svh"

module ilb_lane_fifo (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              clr,
	input  wire logic              wr,
	input  wire logic [`ILB_DW-1:0] wdata,
	input  wire logic              rd,
	output logic [`ILB_DW-1:0]     dout,
	output logic                   dval,
	output logic                   full,
	output logic                   pfull,
	output logic                   empty,
	output logic                   pempty
);
	import ilb_pkg::*;

	ilb_fifo_t s_reg;
	ilb_fifo_t s_next;
	logic      we;
	logic      re;

	always_comb begin
		s_next = s_reg;
		s_next.dval = 1'b0;
		// Guarded on the count so a late flag can never corrupt pointers
		we = wr && (s_reg.cnt != `ILB_FIFO_FULL_CNT);
		re = rd && (s_reg.cnt != 5'h00);
		if (we) begin
			s_next.mem[s_reg.wp] = wdata;
			s_next.wp = s_reg.wp + 4'h1;
		end
		if (re) begin
			s_next.dout = s_reg.mem[s_reg.rp];
			s_next.rp = s_reg.rp + 4'h1;
			s_next.dval = 1'b1;
		end
		if (we && !re) begin
			s_next.cnt = s_reg.cnt + 5'h01;
		end else if (re && !we) begin
			s_next.cnt = s_reg.cnt - 5'h01;
		end
		if (clr) begin
			s_next.wp = '0;
			s_next.rp = '0;
			s_next.cnt = '0;
			s_next.dval = 1'b0;
		end
		s_next.full = (s_next.cnt == `ILB_FIFO_FULL_CNT);
		s_next.pfull = (s_next.cnt >= `ILB_FIFO_PFULL_CNT);
		s_next.empty = (s_next.cnt == 5'h00);
		s_next.pempty = (s_next.cnt < `ILB_FIFO_PEMPTY_CNT);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '0;
			s_reg.empty <= 1'b1;
			s_reg.pempty <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign dout = s_reg.dout;
	assign dval = s_reg.dval;
	assign full = s_reg.full;
	assign pfull = s_reg.pfull;
	assign empty = s_reg.empty;
	assign pempty = s_reg.pempty;

endmodule

// ---- design/ilb_dev.sv ----
`include "ilb_defines.svh"

module ilb_dev (
	input  wire logic             CLK,
	input  wire logic             RST,
	ilb_if.dev                    LNK,
	input  wire ilb_pkg::ilb_lanes_t     LANE_TX_LOCK,
	input  wire ilb_pkg::ilb_lanes_t     LANE_RX_LOCK,
	input  wire ilb_pkg::ilb_lane_data_t LANE_RX_WORD,
	input  wire ilb_pkg::ilb_lanes_t     LANE_RX_VALID,
	input  wire ilb_pkg::ilb_lanes_t     LANE_RX_SYNC,
	output ilb_pkg::ilb_lane_data_t      LANE_TX_WORD,
	output ilb_pkg::ilb_lanes_t          LANE_TX_VALID
);
	import ilb_pkg::*;

	ilb_dev_t           s_reg;
	ilb_dev_t           s_next;
	ilb_lanes_t         rx_wr;
	logic [`ILB_DW-1:0] wmask;

	// Single-rate fabric path only: no double rate option exists
	always_comb begin
		s_next = s_reg;
		s_next.tx_lock = LANE_TX_LOCK;
		s_next.rx_lock = LANE_RX_LOCK;
		wmask = ilb_width_mask(LNK.width_sel);
		for (int i = 0; i < `ILB_LANES; i++) begin
			// Capture starts at the first sync word after lock
			rx_wr[i] = s_reg.rx_lock[i] && LANE_RX_VALID[i]
				&& (s_reg.sync_seen[i] || LANE_RX_SYNC[i]);
			s_next.sync_seen[i] = s_reg.rx_lock[i] && !LNK.rx_align_clr
				&& (s_reg.sync_seen[i]
				|| (LANE_RX_VALID[i] && LANE_RX_SYNC[i]));
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign LNK.tx_lock = s_reg.tx_lock;
	assign LNK.rx_frame_lock = s_reg.rx_lock;

	// Up to 24 lanes, each its own channel with elastic FIFOs
	for (genvar g = 0; g < `ILB_LANES; g++) begin : g_lane
		ilb_lane_fifo u_tx (
			.CLK    (CLK),
			.RST    (RST),
			.clr    (LNK.tx_digital_reset),
			.wr     (LNK.tx_wr_en[g]),
			.wdata  (LNK.tx_data[g] & wmask),
			.rd     (LNK.tx_burst_en),
			.dout   (LANE_TX_WORD[g]),
			.dval   (LANE_TX_VALID[g]),
			.full   (LNK.tx_full[g]),
			.pfull  (LNK.tx_pfull[g]),
			.empty  (LNK.tx_empty[g]),
			.pempty (LNK.tx_pempty[g])
		);
		ilb_lane_fifo u_rx (
			.CLK    (CLK),
			.RST    (RST),
			.clr    (LNK.rx_align_clr),
			.wr     (rx_wr[g]),
			.wdata  (LANE_RX_WORD[g] & wmask),
			.rd     (LNK.rx_rd_en[g]),
			.dout   (LNK.rx_data[g]),
			.dval   (LNK.rx_dval[g]),
			.full   (),
			.pfull  (LNK.rx_pfull[g]),
			.empty  (LNK.rx_empty[g]),
			.pempty (LNK.rx_pempty[g])
		);
	end

endmodule

// ---- sim/ilb_link_checker.sv ----
module ilb_link_checker (
	input wire logic                CLK,
	input wire logic                RST,
	input wire ilb_pkg::ilb_lanes_t tx_wr_en,
	input wire ilb_pkg::ilb_lanes_t tx_full,
	input wire ilb_pkg::ilb_lanes_t tx_empty,
	input wire ilb_pkg::ilb_lanes_t tx_lock,
	input wire logic                tx_burst_en,
	input wire logic                tx_digital_reset,
	input wire ilb_pkg::ilb_lanes_t rx_rd_en,
	input wire ilb_pkg::ilb_lanes_t rx_pfull,
	input wire ilb_pkg::ilb_lanes_t rx_pempty,
	input wire logic                rx_align_clr
);
	timeunit 1ns;
	timeprecision 1ps;
	import ilb_pkg::*;

	logic [7:0] lock_cnt_reg;
	ilb_lanes_t fill_mask_reg;

	// Lanes written while burst is off are the pre-fill set
	always_ff @(posedge CLK) begin
		if (RST || !tx_lock[0]) begin
			lock_cnt_reg <= 8'h00;
		end else if (lock_cnt_reg != 8'hFF) begin
			lock_cnt_reg <= lock_cnt_reg + 8'h01;
		end
		if (RST || tx_digital_reset) begin
			fill_mask_reg <= '0;
		end else if (!tx_burst_en) begin
			fill_mask_reg <= fill_mask_reg | tx_wr_en;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// Flags lag writes by one edge; three quiet cycles cover it
	sequence s_tx_quiet;
		!tx_burst_en && tx_wr_en == '0 && !tx_digital_reset;
	endsequence

	a_rd_all_clear: assert property ($rose(|rx_rd_en) |->
		($past(rx_pempty) & rx_rd_en) == '0)
		else $error("read enable raised while a lane was partially empty");
	a_flush_four: assert property ($rose(rx_align_clr) |->
		rx_align_clr[*4] ##1 !rx_align_clr)
		else $error("align clear not high for exactly four cycles");
	a_flush_cause: assert property (
		(|rx_pfull) && rx_rd_en == '0 && !rx_align_clr |-> ##[1:3] rx_align_clr)
		else $error("partially full lane did not start a flush");
	a_flush_no_read: assert property (rx_align_clr |-> rx_rd_en == '0)
		else $error("read enable high during flush");
	a_fill_after_lock: assert property (
		(|tx_wr_en) && !tx_burst_en |-> lock_cnt_reg >= 8'h19)
		else $error("pre-fill write too soon after lock");
	a_no_full_write: assert property (
		tx_burst_en |-> (tx_wr_en & tx_full) == '0)
		else $error("write into a full TX FIFO while running");
	a_burst_full: assert property (
		$rose(tx_burst_en) && fill_mask_reg != '0 |->
		(tx_full & fill_mask_reg) == fill_mask_reg)
		else $error("burst enabled before all lanes full");
	a_hold_no_pop: assert property (s_tx_quiet[*3] |=>
		$stable(tx_empty) && $stable(tx_full))
		else $error("TX FIFO level moved without burst or write");

	c_flush: cover property ($rose(rx_align_clr));
	c_align: cover property ($rose(|rx_rd_en));
	c_bonded: cover property ($rose(tx_burst_en) && fill_mask_reg != '0);
endmodule

// ---- sim/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ilb_pkg::*;

	// High bits set so a narrow lane width shows in the popped word
	localparam logic [63:0] tx_k0 = 64'hFF00_0000_0000_0001;

	typedef struct packed {
		logic [11:0] a;
		logic        w;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} ilb_row_t;

	logic           clk;
	logic           rst;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [11:0]    paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic           irq;
	ilb_lane_data_t mac_tx_data;
	ilb_lane_data_t mac_rx_data;
	ilb_lane_data_t lane_rx_word;
	ilb_lane_data_t lane_tx_word;
	logic           mac_tx_valid;
	logic           mac_tx_ready;
	logic           mac_rx_valid;
	ilb_lanes_t     lane_tx_lock;
	ilb_lanes_t     lane_rx_lock;
	ilb_lanes_t     lane_rx_valid;
	ilb_lanes_t     lane_rx_sync;
	ilb_lanes_t     lane_tx_valid;
	logic [63:0]    tx_k;
	logic [31:0]    rd;
	logic           er;
	int             fail_count;
	int             comparisons;
	int             n;
	int             clr_n;
	int             rd_any;
	ilb_row_t       rows [8];

	ilb_if ilb_if_inst ();

	ilb_host ilb_host_inst (.CLK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
		.MAC_TX_DATA(mac_tx_data), .MAC_TX_VALID(mac_tx_valid),
		.MAC_TX_READY(mac_tx_ready), .MAC_RX_DATA(mac_rx_data),
		.MAC_RX_VALID(mac_rx_valid), .LNK(ilb_if_inst));

	ilb_dev ilb_dev_inst (.CLK(clk), .RST(rst), .LNK(ilb_if_inst),
		.LANE_TX_LOCK(lane_tx_lock), .LANE_RX_LOCK(lane_rx_lock),
		.LANE_RX_WORD(lane_rx_word), .LANE_RX_VALID(lane_rx_valid),
		.LANE_RX_SYNC(lane_rx_sync), .LANE_TX_WORD(lane_tx_word),
		.LANE_TX_VALID(lane_tx_valid));

	ilb_link_checker ilb_link_checker_inst (.CLK(clk), .RST(rst),
		.tx_wr_en(ilb_if_inst.tx_wr_en), .tx_full(ilb_if_inst.tx_full),
		.tx_empty(ilb_if_inst.tx_empty), .tx_lock(ilb_if_inst.tx_lock),
		.tx_burst_en(ilb_if_inst.tx_burst_en),
		.tx_digital_reset(ilb_if_inst.tx_digital_reset),
		.rx_rd_en(ilb_if_inst.rx_rd_en), .rx_pfull(ilb_if_inst.rx_pfull),
		.rx_pempty(ilb_if_inst.rx_pempty),
		.rx_align_clr(ilb_if_inst.rx_align_clr));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Zero wait states expected; only the watchdog ends a stall
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps the next setup out of this time step
		@(posedge clk);
	endtask

	task automatic finish_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Streaming source keeps the bonded FIFOs from running dry
	always @(posedge clk) begin
		if (rst) begin
			tx_k <= tx_k0;
			mac_tx_data <= {24{tx_k0}};
		end else if (mac_tx_valid && mac_tx_ready) begin
			tx_k <= tx_k + 64'h1;
			mac_tx_data <= {24{tx_k + 64'h1}};
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#50000;
		fail_count++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		mac_tx_valid = 1'b0;
		lane_tx_lock = '0;
		lane_rx_lock = '0;
		lane_rx_word = '0;
		lane_rx_valid = '0;
		lane_rx_sync = '0;
		rows = '{'{12'h000, 1'b1, 32'h0000_0089, 32'h0, 1'b0},
			'{12'h000, 1'b0, 32'h0, 32'h0000_0089, 1'b0},
			'{12'h00C, 1'b1, 32'h0000_000F, 32'h0, 1'b0},
			'{12'h00C, 1'b0, 32'h0, 32'h0000_000F, 1'b0},
			'{12'h00C, 1'b1, 32'h0, 32'h0, 1'b0},
			'{12'h010, 1'b0, 32'h0, 32'h0, 1'b0},
			'{12'h020, 1'b0, 32'h0, 32'h0, 1'b1},
			'{12'h014, 1'b1, 32'h0000_0001, 32'h0, 1'b1}};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			chk(er, rows[i].e);
			if (!rows[i].w) chk(rd, rows[i].x);
		end
		// Four bonded lanes: lock, wait, pre-fill, then run
		lane_tx_lock <= '1;
		n = 0;
		while (mac_tx_ready !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(mac_tx_ready, 1'b1);
		mac_tx_valid <= 1'b1;
		n = 0;
		while (!(lane_tx_valid[0] === 1'b1 && lane_tx_word[0] !== '0)
			&& n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(lane_tx_word[0], tx_k0);
		chk(lane_tx_word[3], tx_k0);
		@(posedge clk);
		chk(lane_tx_word[0], tx_k0 + 64'h1);
		// Skewed lanes, junk before the sync word on lanes 1 to 3
		lane_rx_lock <= '1;
		repeat (3) @(posedge clk);
		fork
			for (int c = 0; c < 30; c++) begin
				for (int i = 0; i < 4; i++) begin
					lane_rx_valid[i] <= 1'b1;
					lane_rx_sync[i] <= (c == i);
					lane_rx_word[i] <= (c < i) ? 64'hDEAD_0000_0000_BEEF
						: 64'h100 + 64'(c - i);
				end
				@(posedge clk);
			end
			begin
				n = 0;
				while (mac_rx_valid !== 1'b1 && n < 30) begin
					@(posedge clk);
					n++;
				end
				chk(mac_rx_data[0], 64'h100);
				chk(mac_rx_data[3], 64'h100);
			end
		join
		lane_rx_valid <= '0;
		lane_rx_sync <= '0;
		lane_rx_lock <= '0;
		repeat (10) @(posedge clk);
		lane_rx_lock <= '1;
		repeat (3) @(posedge clk);
		// Lane 3 never finds sync, so lanes 0 to 2 fill up first
		clr_n = 0;
		rd_any = 0;
		for (int c = 0; c < 30; c++) begin
			lane_rx_valid[3:0] <= 4'hF;
			lane_rx_sync[2:0] <= (c == 0) ? 3'h7 : 3'h0;
			@(posedge clk);
			clr_n = clr_n + int'(ilb_if_inst.rx_align_clr);
			rd_any = rd_any + int'(|ilb_if_inst.rx_rd_en);
		end
		lane_rx_valid <= '0;
		chk(clr_n, 4);
		chk(rd_any, 0);
		apb(12'h008, 1'b0, 32'h0);
		chk(rd, 32'h0000_000D);
		chk(irq, 1'b0);
		apb(12'h00C, 1'b1, 32'h0000_0008);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		apb(12'h010, 1'b1, 32'h0000_0008);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(12'h008, 1'b0, 32'h0);
		chk(rd, 32'h0000_0005);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(12'h000, 1'b0, 32'h0);
		chk(rd, 32'h0000_0082);
		apb(12'h004, 1'b0, 32'h0);
		chk(rd, 32'h0000_0021);
		chk(irq, 1'b0);
		// One lane, 32-bit width: no pre-fill wait, high bits masked
		apb(12'h000, 1'b1, 32'h0000_0003);
		n = 0;
		while (mac_tx_ready !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(n < 25, 1'b1);
		n = 0;
		while (lane_tx_valid[0] !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(lane_tx_word[0], 64'h0000_0000_0000_0001);
		finish_test();
	end
endmodule
